// *** cbrs_pkg.sv ***
package cbrs_pkg;

  localparam logic [7:0]  CONV_CTRL_OFS     = 8'hD1;
  localparam logic [7:0]  STATUS_OFS        = 8'hD4;
  localparam logic [7:0]  CONV_CTRL_RESET   = 8'h40;
  localparam int          MAIN_OSC_OFF_BIT  = 2;
  localparam logic [11:0] RESET_VECTOR      = 12'hFFE;
  localparam logic [11:0] DELAY_CYCLES      = 12'h800;
  localparam logic [1:0]  FETCH_CYCLES      = 2'h2;
  localparam logic [3:0]  MISS_LIMIT        = 4'h8;
  localparam logic [3:0]  WDOG_PULSE_CYCLES = 4'h4;
  localparam logic [1:0]  AXI_OKAY          = 2'b00;
  localparam logic [1:0]  AXI_SLVERR        = 2'b10;

  typedef enum {
    SEQ_HOLD,
    SEQ_DELAY,
    SEQ_FETCH,
    SEQ_RUN
  } cbrs_seq_t;

  typedef struct packed {
    logic        hold;
    logic        delay;
    logic        fetch;
    logic        run;
  } cbrs_phase_t;

endpackage

// *** cbrs_sequencer.sv ***
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - backup oscillator usable only when safeguard option strap is set
// - with safeguard, missing main edges switch internal clock to backup
// - on backup clock, cpu keeps running, interrupts and wait/stop normal
// - at power-on backup clocks delay counter until main oscillator starts
// - backup oscillator stops as soon as main oscillator runs
// - converter control bit 2 disables main oscillator; at 0xD1, reset 0x40
// - without safeguard, main oscillator disable bit has no effect
// - enabled low-voltage detector below threshold holds static reset
// - reset pin driven low while low-voltage reset is active
// - reset sources: pin, watchdog, low-voltage detector only
// - after reset wait 2048 internal cycles, then 2 vector fetch cycles
// - reset clears return stack and loads pc with vector 0xFFE
// - reset enters nmi mode, left on return-from-interrupt
// - pin low holds reset; short pulse accepted due to appended delay
// - pin low in run/wait halts cpu, ports to pull-up inputs, osc restart
// - pin low in stop starts oscillator and sets ports to pull-up inputs
// - watchdog end-of-count resets exactly like pin reset
// - watchdog reset pulses reset pin low only briefly
module cbrs_sequencer (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // option straps
  input  wire logic        safeguard_option_i,
  input  wire logic        lv_detect_option_i,
  // analog / peripheral events
  input  wire logic        main_osc_edge_i,
  input  wire logic        low_voltage_detector_i,
  input  wire logic        watchdog_reset_i,
  input  wire logic        return_from_interrupt_instr_i,
  input  wire logic        stop_mode_i,
  // reset pin, open drain
  input  wire logic        reset_pin_n_i,
  output logic             reset_pin_o,
  output logic             reset_pin_oe_o,
  // clock and core control
  output logic             main_osc_enable_o,
  output logic             backup_low_freq_osc_en_o,
  output logic             clk_sel_backup_o,
  output logic             cpu_reset_o,
  output logic             ports_to_pullup_o,
  output logic             stack_clear_o,
  output logic             vector_fetch_o,
  output logic [11:0]      pc_load_value_o,
  output logic             nmi_mode_o,
  output logic [7:0]       converter_control_o,
  // axi4-lite slave
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers, three stages

  logic [2:0] pin_sync;
  logic [2:0] edge_sync;
  logic [2:0] lv_sync;
  logic       pin_low;
  logic       main_edge_lvl;
  logic       lv_low;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_sync  <= 3'h7;
      edge_sync <= 3'h0;
      lv_sync   <= 3'h0;
    end else begin
      pin_sync  <= {pin_sync[1:0], reset_pin_n_i};
      edge_sync <= {edge_sync[1:0], main_osc_edge_i};
      lv_sync   <= {lv_sync[1:0], low_voltage_detector_i};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_low       <= 1'b0;
      main_edge_lvl <= 1'b0;
      lv_low        <= 1'b0;
    end else begin
      if (pin_sync[1] == pin_sync[2]) begin
        pin_low <= ~pin_sync[2];
      end
      if (edge_sync[1] == edge_sync[2]) begin
        main_edge_lvl <= edge_sync[2];
      end
      if (lv_sync[1] == lv_sync[2]) begin
        lv_low <= lv_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter control register and oscillator supervision

  logic [7:0] conv_ctrl;
  logic       edge_prev;
  logic [3:0] miss_cnt;
  logic       main_running;

  // main declared missing after a quiet window of MISS_LIMIT cycles
  wire edge_seen = main_edge_lvl ^ edge_prev;
  wire osc_off_eff =
    conv_ctrl[cbrs_pkg::MAIN_OSC_OFF_BIT] & safeguard_option_i;
  wire miss_full = miss_cnt == cbrs_pkg::MISS_LIMIT;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edge_prev    <= 1'b0;
      miss_cnt     <= 4'h0;
      main_running <= 1'b0;
    end else begin
      edge_prev <= main_edge_lvl;
      if (edge_seen) begin
        miss_cnt     <= 4'h0;
        main_running <= 1'b1;
      end else if (!miss_full) begin
        miss_cnt <= miss_cnt + 4'h1;
      end else begin
        main_running <= 1'b0;
      end
    end
  end

  // backup runs only with safeguard and no main clock
  wire backup_on = safeguard_option_i & ~main_running;
  assign backup_low_freq_osc_en_o = backup_on;
  assign clk_sel_backup_o         = backup_on;

  ////////////////////////////////////////////////////////////////////////////
  // reset merge and sequence

  cbrs_pkg::cbrs_seq_t state;
  cbrs_pkg::cbrs_seq_t next_state;
  logic [11:0]         delay_cnt;
  logic [1:0]          fetch_cnt;
  logic                nmi_mode;
  logic [3:0]          wdog_cnt;
  logic                stop_at_reset;

  // any source forces hold on the next edge
  wire lv_reset  = lv_detect_option_i & lv_low;
  wire any_reset = pin_low | watchdog_reset_i | lv_reset;
  wire delay_done = delay_cnt == cbrs_pkg::DELAY_CYCLES - 12'h001;
  wire fetch_done = fetch_cnt == cbrs_pkg::FETCH_CYCLES - 2'h1;

  always_comb begin
    next_state = state;
    case (state)
      cbrs_pkg::SEQ_HOLD: begin
        if (!any_reset) begin
          next_state = cbrs_pkg::SEQ_DELAY;
        end
      end
      cbrs_pkg::SEQ_DELAY: begin
        if (delay_done) begin
          next_state = cbrs_pkg::SEQ_FETCH;
        end
      end
      cbrs_pkg::SEQ_FETCH: begin
        if (fetch_done) begin
          next_state = cbrs_pkg::SEQ_RUN;
        end
      end
      cbrs_pkg::SEQ_RUN: begin
        next_state = cbrs_pkg::SEQ_RUN;
      end
      default: begin
        next_state = cbrs_pkg::SEQ_HOLD;
      end
    endcase
    if (any_reset) begin
      next_state = cbrs_pkg::SEQ_HOLD;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= cbrs_pkg::SEQ_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // counter runs on whichever clock is selected; mclk stands for it
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      delay_cnt <= 12'h000;
      fetch_cnt <= 2'h0;
    end else begin
      if (state == cbrs_pkg::SEQ_DELAY) begin
        delay_cnt <= delay_cnt + 12'h001;
      end else begin
        delay_cnt <= 12'h000;
      end
      if (state == cbrs_pkg::SEQ_FETCH) begin
        fetch_cnt <= fetch_cnt + 2'h1;
      end else begin
        fetch_cnt <= 2'h0;
      end
    end
  end

  // nmi mode held through reset, left on the first return
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nmi_mode <= 1'b1;
    end else if (state != cbrs_pkg::SEQ_RUN) begin
      nmi_mode <= 1'b1;
    end else if (return_from_interrupt_instr_i) begin
      nmi_mode <= 1'b0;
    end
  end

  // pin pulse after watchdog, too short for board reset
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdog_cnt <= 4'h0;
    end else if (watchdog_reset_i) begin
      wdog_cnt <= cbrs_pkg::WDOG_PULSE_CYCLES;
    end else if (wdog_cnt != 4'h0) begin
      wdog_cnt <= wdog_cnt - 4'h1;
    end
  end

  // whether the pin reset found the cpu stopped
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stop_at_reset <= 1'b0;
    end else if (state == cbrs_pkg::SEQ_RUN && pin_low) begin
      stop_at_reset <= stop_mode_i;
    end
  end

  // one-hot view of the sequence state
  cbrs_pkg::cbrs_phase_t phase;
  assign phase.hold  = state == cbrs_pkg::SEQ_HOLD;
  assign phase.delay = state == cbrs_pkg::SEQ_DELAY;
  assign phase.fetch = state == cbrs_pkg::SEQ_FETCH;
  assign phase.run   = state == cbrs_pkg::SEQ_RUN;

  // open drain: the pin is only ever pulled low
  wire pin_drive = lv_reset | (wdog_cnt != 4'h0);
  assign reset_pin_o    = 1'b0;
  assign reset_pin_oe_o = pin_drive;

  // reset restarts main oscillator regardless of disable bit
  assign main_osc_enable_o = ~osc_off_eff | ~phase.run;
  assign cpu_reset_o       = ~phase.run;
  assign ports_to_pullup_o = phase.hold | phase.delay;
  assign stack_clear_o     = ~phase.run;
  assign vector_fetch_o    = phase.fetch;
  assign pc_load_value_o   = cbrs_pkg::RESET_VECTOR;
  assign nmi_mode_o        = nmi_mode;
  assign converter_control_o = conv_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic        aw_hold;
  logic        w_hold;
  logic [9:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;

  assign s_axi_awready = ~aw_hold & ~bvalid;
  assign s_axi_wready  = ~w_hold & ~bvalid;
  assign s_axi_arready = ~rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_hold | aw_take;
  wire have_w  = w_hold | w_take;
  wire [9:0]  wr_addr = aw_hold ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_hold ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_hold ? w_strb : s_axi_wstrb;
  wire wr_go   = have_aw & have_w & ~bvalid;
  // byte address is four times the register index
  wire [9:0] ctrl_addr = {cbrs_pkg::CONV_CTRL_OFS, 2'h0};
  wire [9:0] stat_addr = {cbrs_pkg::STATUS_OFS, 2'h0};
  wire wr_ctrl = wr_addr == ctrl_addr;
  wire wr_stat = wr_addr == stat_addr;
  wire [1:0] wr_resp = (wr_ctrl | wr_stat) ? cbrs_pkg::AXI_OKAY
                                           : cbrs_pkg::AXI_SLVERR;
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire rd_ctrl = s_axi_araddr == ctrl_addr;
  wire rd_stat = s_axi_araddr == stat_addr;
  wire [1:0] rd_resp = (rd_ctrl | rd_stat) ? cbrs_pkg::AXI_OKAY
                                           : cbrs_pkg::AXI_SLVERR;
  // status bits, highest first; bit 8 is stop mode at pin reset
  wire [31:0] status_word = {23'h000000, stop_at_reset, nmi_mode,
    phase.run, phase.fetch, phase.delay, pin_drive, lv_reset,
    backup_on, main_running};
  wire [31:0] rd_word = rd_ctrl ? {24'h000000, conv_ctrl}
                      : (rd_stat ? status_word : 32'h00000000);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 10'h000;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      aw_hold <= have_aw & ~wr_go;
      w_hold  <= have_w & ~wr_go;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // register write; only byte lane 0 holds bits
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_ctrl <= cbrs_pkg::CONV_CTRL_RESET;
      bvalid    <= 1'b0;
      bresp     <= cbrs_pkg::AXI_OKAY;
    end else begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_resp;
        if (wr_ctrl && wr_strb[0]) begin
          conv_ctrl <= wr_data[7:0];
        end
      end else if (s_axi_bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= cbrs_pkg::AXI_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rresp  <= rd_resp;
      rdata  <= rd_word;
    end else if (s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// *** cbrs_sequencer_asserts.sv ***
`timescale 1ns/1ps
module cbrs_sequencer_asserts (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        safeguard_option_i,
  input wire logic        lv_detect_option_i,
  input wire logic        main_osc_edge_i,
  input wire logic        low_voltage_detector_i,
  input wire logic        watchdog_reset_i,
  input wire logic        return_from_interrupt_instr_i,
  input wire logic        reset_pin_n_i,
  input wire logic        reset_pin_oe_o,
  input wire logic        main_osc_enable_o,
  input wire logic        backup_low_freq_osc_en_o,
  input wire logic        cpu_reset_o,
  input wire logic        ports_to_pullup_o,
  input wire logic        vector_fetch_o,
  input wire logic [11:0] pc_load_value_o,
  input wire logic        nmi_mode_o,
  input wire logic [7:0]  converter_control_o
);
  logic       last_edge;
  logic [3:0] stall;
  logic [3:0] runs;
  logic       tog;
  assign tog = main_osc_edge_i != last_edge;
  // cycles since last / run of main oscillator toggles
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_edge <= 1'b0;
      stall     <= 4'h0;
      runs      <= 4'h0;
    end else begin
      last_edge <= main_osc_edge_i;
      stall     <= tog ? 4'h0 : stall + 4'(stall != 4'hF);
      runs      <= (tog || stall == 4'h0) ? runs + 4'(runs != 4'hF) : 4'h0;
    end
  end
  default clocking dc @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence fetch_two;
    vector_fetch_o ##1 vector_fetch_o ##1 !vector_fetch_o;
  endsequence
  a_fetch_two: assert property ($rose(vector_fetch_o) |-> fetch_two)
    else $error("vector fetch length wrong");
  a_fetch_vector: assert property (vector_fetch_o |->
    pc_load_value_o == 12'hFFE && nmi_mode_o)
    else $error("fetch without vector or nmi mode");
  a_rti_leaves: assert property
    (return_from_interrupt_instr_i && !cpu_reset_o |=> !nmi_mode_o)
    else $error("nmi mode kept after return");
  a_wdog_reset: assert property
    (watchdog_reset_i |=> cpu_reset_o && reset_pin_oe_o)
    else $error("watchdog did not reset");
  a_wdog_brief: assert property ($fell(watchdog_reset_i)
    && !lv_detect_option_i |-> ##[1:8] !reset_pin_oe_o)
    else $error("watchdog pin pulse too long");
  a_lv_hold: assert property
    ((lv_detect_option_i && low_voltage_detector_i)[*6]
    |-> cpu_reset_o && reset_pin_oe_o)
    else $error("low voltage reset not held");
  a_pin_hold: assert property ((!reset_pin_n_i)[*6]
    |-> cpu_reset_o && ports_to_pullup_o && main_osc_enable_o)
    else $error("pin reset not held");
  a_no_backup: assert property (!safeguard_option_i
    |-> !backup_low_freq_osc_en_o && main_osc_enable_o)
    else $error("oscillator control without safeguard");
  a_osc_off: assert property ((safeguard_option_i && !cpu_reset_o
    && converter_control_o[2])[*3] |-> !main_osc_enable_o)
    else $error("main oscillator not disabled");
  a_backup_on: assert property
    (safeguard_option_i && stall == 4'hF |-> backup_low_freq_osc_en_o)
    else $error("backup not started");
  a_backup_off: assert property
    (runs == 4'hC |-> ##[0:4] !backup_low_freq_osc_en_o)
    else $error("backup not stopped");
endmodule

// *** cbrs_board.sv ***
`timescale 1ns/1ps
module cbrs_board (
  input  wire logic mclk_i,
  input  wire logic press_i,
  input  wire logic pin_oe_i,
  input  wire logic pin_val_i,
  input  wire logic osc_en_i,
  output logic      pin_o,
  output logic      osc_edge_o
);
  logic half = 1'b0;
  // pin has a pull-up; low while the button or the device pulls it
  assign pin_o = !press_i && !(pin_oe_i && !pin_val_i);
  initial osc_edge_o = 1'b0;
  // main oscillator toggles every second cycle, frozen while disabled
  always @(negedge mclk_i) begin
    if (osc_en_i) begin
      half <= !half;
      if (half) osc_edge_o <= !osc_edge_o;
    end
  end
endmodule

// *** cbrs_sequencer_tb.sv ***
`timescale 1ns/1ps
module cbrs_sequencer_tb;
  logic mclk_i = 0, nrst_i = 0, safeguard_option_i = 0, press = 0;
  logic low_voltage_detector_i = 0, watchdog_reset_i = 0;
  logic lv_detect_option_i = 0;
  logic return_from_interrupt_instr_i = 0, stop_mode_i = 0;
  logic main_osc_edge_i, reset_pin_n_i, reset_pin_oe_o, main_osc_enable_o;
  logic backup_low_freq_osc_en_o, clk_sel_backup_o, cpu_reset_o, nmi_mode_o;
  logic ports_to_pullup_o, stack_clear_o, vector_fetch_o, pin_val;
  logic [11:0] pc_load_value_o;
  logic [7:0]  converter_control_o;
  logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [31:0] seed = 32'hD566;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];
  int error_cnt = 0, compares = 0, nd, nf;
  cbrs_sequencer uut (.mclk_i, .nrst_i, .safeguard_option_i,
    .lv_detect_option_i, .main_osc_edge_i, .low_voltage_detector_i,
    .watchdog_reset_i,
    .return_from_interrupt_instr_i, .stop_mode_i, .reset_pin_n_i,
    .reset_pin_o(pin_val), .reset_pin_oe_o, .main_osc_enable_o,
    .backup_low_freq_osc_en_o, .clk_sel_backup_o, .cpu_reset_o,
    .ports_to_pullup_o, .stack_clear_o, .vector_fetch_o, .pc_load_value_o,
    .nmi_mode_o, .converter_control_o, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  cbrs_board board (.mclk_i, .press_i(press), .pin_oe_i(reset_pin_oe_o),
    .pin_val_i(pin_val),
    .osc_en_i(main_osc_enable_o), .pin_o(reset_pin_n_i),
    .osc_edge_o(main_osc_edge_i));
  always #25 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] dd, input logic [33:0] e);
    logic ta, tw, tr, td;
    exp_q.push_back(e);
    @(posedge mclk_i);
    if (wr) begin
      s_axi_awaddr <= {a, 2'h0};
      s_axi_wdata <= dd;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
    end else begin
      s_axi_araddr <= {a, 2'h0};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
    end
    for (int n = 0; n < 50; n++) begin
      @(negedge mclk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      td = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
      @(posedge mclk_i);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
      if (td) begin
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        return;
      end
    end
    error_cnt++;
    wrap_up();
  endtask
  // counts hold and delay cycles and fetch cycles of one reset sequence
  task automatic wait_fetch(output int dn, output int fn);
    dn = 0;
    fn = 0;
    for (int i = 0; i < 4000 && !(fn > 0 && !vector_fetch_o); i++) begin
      @(negedge mclk_i);
      if (vector_fetch_o === 1'b1) fn++;
      else if (fn == 0 && ports_to_pullup_o === 1'b1) dn++;
    end
    if (fn == 0) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  always @(negedge mclk_i) begin
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1;
    wait_fetch(nd, nf);
    check(34'(nd), 34'h801);
    check(34'(nf), 34'h2);
    check(34'({nmi_mode_o, cpu_reset_o, stack_clear_o, pc_load_value_o}),
      34'h4FFE);
    @(posedge mclk_i) return_from_interrupt_instr_i <= 1;
    @(posedge mclk_i) return_from_interrupt_instr_i <= 0;
    @(negedge mclk_i) check(34'(nmi_mode_o), 34'h0);
    bus(0, cbrs_pkg::CONV_CTRL_OFS, 0, {cbrs_pkg::AXI_OKAY, 32'h40});
    bus(0, 8'h10, 0, {cbrs_pkg::AXI_SLVERR, 32'h0});
    bus(1, 8'h10, 0, {cbrs_pkg::AXI_SLVERR, 32'h0});
    d = xs() | 32'h4;
    bus(1, cbrs_pkg::CONV_CTRL_OFS, d, {cbrs_pkg::AXI_OKAY, 32'h0});
    bus(0, cbrs_pkg::CONV_CTRL_OFS, 0, {cbrs_pkg::AXI_OKAY, 24'h0, d[7:0]});
    repeat (30) @(negedge mclk_i);
    check(34'({main_osc_enable_o, backup_low_freq_osc_en_o}), 34'h2);
    @(posedge mclk_i) safeguard_option_i <= 1;
    repeat (30) @(negedge mclk_i);
    check(34'({main_osc_enable_o, backup_low_freq_osc_en_o, clk_sel_backup_o,
      cpu_reset_o}), 34'h6);
    bus(1, cbrs_pkg::CONV_CTRL_OFS, d & ~32'h4, {cbrs_pkg::AXI_OKAY, 32'h0});
    repeat (30) @(negedge mclk_i);
    check(34'({main_osc_enable_o, backup_low_freq_osc_en_o}), 34'h2);
    for (int s = 0; s < 2; s++) begin
      bus(1, cbrs_pkg::CONV_CTRL_OFS, xs() | 32'h4, {cbrs_pkg::AXI_OKAY, 32'h0});
      @(posedge mclk_i);
      stop_mode_i <= 1'(s);
      press <= 1;
      repeat (8) @(posedge mclk_i);
      press <= 0;
      @(negedge mclk_i);
      check(34'({cpu_reset_o, ports_to_pullup_o, main_osc_enable_o,
        stack_clear_o}), 34'hF);
      wait_fetch(nd, nf);
      check(34'({nmi_mode_o, nf[1:0]}), 34'h6);
    end
    @(posedge mclk_i) watchdog_reset_i <= 1;
    @(posedge mclk_i) watchdog_reset_i <= 0;
    @(negedge mclk_i) check(34'({reset_pin_n_i, cpu_reset_o}), 34'h1);
    repeat (10) @(negedge mclk_i);
    check(34'(reset_pin_n_i), 34'h1);
    wait_fetch(nd, nf);
    check(34'(nf), 34'h2);
    @(posedge mclk_i) low_voltage_detector_i <= 1;
    repeat (20) @(negedge mclk_i);
    check(34'(cpu_reset_o), 34'h0);
    @(posedge mclk_i) lv_detect_option_i <= 1;
    repeat (20) @(negedge mclk_i);
    check(34'({cpu_reset_o, reset_pin_n_i}), 34'h2);
    @(posedge mclk_i) low_voltage_detector_i <= 0;
    wait_fetch(nd, nf);
    check(34'(reset_pin_n_i), 34'h1);
    wrap_up();
  end
endmodule
bind cbrs_sequencer cbrs_sequencer_asserts chk (.mclk_i, .nrst_i,
  .safeguard_option_i, .lv_detect_option_i, .main_osc_edge_i,
  .low_voltage_detector_i, .watchdog_reset_i, .return_from_interrupt_instr_i,
  .reset_pin_n_i, .reset_pin_oe_o, .main_osc_enable_o,
  .backup_low_freq_osc_en_o, .cpu_reset_o, .ports_to_pullup_o,
  .vector_fetch_o, .pc_load_value_o, .nmi_mode_o, .converter_control_o);
